/* File: src/sffm_pkg.sv */
// Constants and types for the sensor fault flag monitor
package sffm_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  FAULT_FLAGS_ADDR = 8'hA3;
   localparam logic [7:0]  SQ_RADIUS_ADDR   = 8'hA5;
   localparam logic [31:0] FLAGS_RESET      = 32'h0000_0040;
   // ---------------------------------------------------------------
   // Flag bit positions
   // ---------------------------------------------------------------
   localparam int B_ACF = 0;
   localparam int B_AOC = 1;
   localparam int B_TSE = 2;
   localparam int B_SAT = 3;
   localparam int B_SELFTEST = 4;
   localparam int B_SRR = 5;
   localparam int B_POR = 6;
   localparam int B_ESE = 7;
   localparam int B_UVD = 8;
   localparam int B_OVD = 9;
   localparam int B_NVM_UNCORR = 10;
   localparam int B_SPE = 11;
   localparam int B_OFE = 12;
   localparam int NFLAGS = 13;
   // Flags that only a power-on reset clears
   localparam logic [12:0] CRIT_MASK = 13'h1C00;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ         = 25_000_000;
   localparam int TSE_PERIOD_US  = 1500;
   localparam int TSE_CYC        = TSE_PERIOD_US * (CLK_HZ / 1_000_000);
   localparam int FILT_MAX       = 16;
   localparam int PERIODIC_UPD   = 10;
   // Margin test selection
   typedef enum logic [1:0] {
      MRG_ONES = 2'h1,
      MRG_ZEROS = 2'h2,
      MRG_BOTH = 2'h3
   } sffm_mrg_t;
   typedef enum logic [2:0] {
      MS_IDLE = 3'b001,
      MS_RUN  = 3'b010,
      MS_DONE = 3'b100
   } sffm_ms_t;
endpackage

/* File: src/sffm_top.sv */
// Fault flag collection, clearing and margin test of the position sensor
`timescale 1ns/1ps
module sffm_top
   import sffm_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // Register read port
   input  wire logic        rd_en_i,
   input  wire logic [7:0]  rd_addr_i,
   output logic [31:0]      rd_data_o,
   // Output protocol report strobe
   input  wire logic        report_done_i,
   // Signal path timing and raw conditions
   input  wire logic        angle_upd_i,
   input  wire logic        analog_bad_i,
   input  wire logic        clamp_hit_i,
   input  wire logic        temp_hi_sat_i,
   input  wire logic        temp_lo_i,
   input  wire logic        sat_filt_i,
   input  wire logic        sat_chan_i,
   input  wire logic        pregain_out_i,
   input  wire logic        gain_out_i,
   input  wire logic        postgain_out_i,
   input  wire logic        sat_lin_i,
   input  wire logic        osc_dev_i,
   input  wire logic        logic_selftest_fail_i,
   input  wire logic        upd_late_i,
   input  wire logic        uvd_i,
   input  wire logic        ovd_i,
   input  wire logic        ese_i,
   input  wire logic        nvm_uncorrectable_i,
   input  wire logic        spe_i,
   input  wire logic [15:0] first_axis_value_i,
   input  wire logic [15:0] second_axis_value_i,
   // Nonvolatile configuration
   input  wire logic [12:0] flag_mask_i,
   input  wire logic        sat_filt_mask_i,
   input  wire logic        sat_chan_mask_i,
   input  wire logic        sat_cor_mask_i,
   input  wire logic        sat_lin_mask_i,
   input  wire logic        ang_thresh_en_i,
   input  wire logic        ang_gain_sat_en_i,
   input  wire logic        ang_offs_sat_en_i,
   input  wire logic [3:0]  fault_filt_i,
   input  wire logic [8:0]  thresh_min_i,
   input  wire logic [8:0]  thresh_max_i,
   // Margin test
   input  wire logic        mrg_start_i,
   input  wire logic [1:0]  mrg_sel_i,
   input  wire logic        mrg_cell_ok1_i,
   input  wire logic        mrg_cell_ok0_i,
   output logic             mrg_busy_o,
   output logic [1:0]       mrg_result_o,
   // Diagnostic state
   output logic             fault_state_o
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_s1_r, rst_n;
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   function automatic logic [16:0] sq_rad(input logic [15:0] a, input logic [15:0] b);
      logic [8:0] qa;
      logic [8:0] qb;
      qa = a[15:7];
      qb = b[15:7];
      // Widen before squaring; a 9-bit product would wrap
      sq_rad = 17'(qa) * 17'(qa) + 17'(qb) * 17'(qb);
   endfunction

   // ---------------------------------------------------------------
   // Condition evaluation
   // ---------------------------------------------------------------
   logic [16:0] radius_r, radius_nxt;
   logic [3:0]  aoc_cnt_r, aoc_cnt_nxt, sat_cnt_r, sat_cnt_nxt, srr_cnt_r, srr_cnt_nxt;
   logic [3:0]  upd_cnt_r, upd_cnt_nxt;
   logic [15:0] tse_cnt_r, tse_cnt_nxt;
   logic        first_upd_r, first_upd_nxt;
   logic        sat_cond, srr_cond, tick10, tse_tick;
   logic [31:0] min_sq, max_sq;

   always_comb begin
      min_sq = 32'(thresh_min_i) * 32'(thresh_min_i);
      max_sq = 32'(thresh_max_i) * 32'(thresh_max_i);
      sat_cond = (sat_filt_i & ~sat_filt_mask_i) | (sat_chan_i & ~sat_chan_mask_i)
               | (((pregain_out_i & ang_thresh_en_i) | (gain_out_i & ang_gain_sat_en_i)
               | (postgain_out_i & ang_offs_sat_en_i)) & ~sat_cor_mask_i)
               | (sat_lin_i & ~sat_lin_mask_i);
      radius_nxt = angle_upd_i ? sq_rad(first_axis_value_i, second_axis_value_i) : radius_r;
      srr_cond = !((32'(radius_r) > min_sq) && (32'(radius_r) < max_sq));
      tick10 = angle_upd_i && (upd_cnt_r == 4'(PERIODIC_UPD - 1));
      upd_cnt_nxt = angle_upd_i ? (tick10 ? 4'h0 : upd_cnt_r + 4'h1) : upd_cnt_r;
      tse_tick = (tse_cnt_r == 16'(TSE_CYC - 1));
      tse_cnt_nxt = tse_tick ? 16'h0000 : tse_cnt_r + 16'h0001;
      first_upd_nxt = first_upd_r | angle_upd_i;
      // Fault filter: a persistent condition must last fault_filt + 1 updates
      aoc_cnt_nxt = aoc_cnt_r;
      sat_cnt_nxt = sat_cnt_r;
      srr_cnt_nxt = srr_cnt_r;
      if (angle_upd_i) begin
         aoc_cnt_nxt = !clamp_hit_i ? 4'h0 : (aoc_cnt_r == 4'hF ? aoc_cnt_r : aoc_cnt_r + 4'h1);
         sat_cnt_nxt = !sat_cond ? 4'h0 : (sat_cnt_r == 4'hF ? sat_cnt_r : sat_cnt_r + 4'h1);
         srr_cnt_nxt = !srr_cond ? 4'h0 : (srr_cnt_r == 4'hF ? srr_cnt_r : srr_cnt_r + 4'h1);
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         radius_r    <= 17'h00000;
         aoc_cnt_r   <= 4'h0;
         sat_cnt_r   <= 4'h0;
         srr_cnt_r   <= 4'h0;
         upd_cnt_r   <= 4'h0;
         tse_cnt_r   <= 16'h0000;
         first_upd_r <= 1'b0;
      end else begin
         radius_r    <= radius_nxt;
         aoc_cnt_r   <= aoc_cnt_nxt;
         sat_cnt_r   <= sat_cnt_nxt;
         srr_cnt_r   <= srr_cnt_nxt;
         upd_cnt_r   <= upd_cnt_nxt;
         tse_cnt_r   <= tse_cnt_nxt;
         first_upd_r <= first_upd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Flag register
   // ---------------------------------------------------------------
   logic [12:0] set_v, flags_r, flags_nxt, clr_v;
   logic        rd_flags;
   always_comb begin
      set_v = '0;
      set_v[B_ACF] = analog_bad_i;
      set_v[B_AOC] = angle_upd_i && clamp_hit_i && (aoc_cnt_r >= fault_filt_i);
      set_v[B_TSE] = tse_tick && (temp_hi_sat_i || temp_lo_i);
      set_v[B_SAT] = angle_upd_i && sat_cond && (sat_cnt_r >= fault_filt_i);
      set_v[B_SELFTEST] = tick10 && (logic_selftest_fail_i || upd_late_i);
      set_v[B_SRR] = angle_upd_i && srr_cond && (srr_cnt_r >= fault_filt_i);
      set_v[B_ESE] = ese_i;
      set_v[B_UVD] = uvd_i;
      set_v[B_OVD] = ovd_i;
      set_v[B_NVM_UNCORR] = nvm_uncorrectable_i;
      set_v[B_SPE] = spe_i;
      set_v[B_OFE] = tick10 && osc_dev_i;
      set_v = set_v & ~flag_mask_i;
      rd_flags = rd_en_i && (rd_addr_i == FAULT_FLAGS_ADDR);
      clr_v = (rd_flags || report_done_i) ? ~CRIT_MASK : 13'h0000;
      clr_v[B_ESE] = rd_flags;
      clr_v[B_POR] = (rd_flags || report_done_i) && first_upd_r;
      flags_nxt = (flags_r & ~clr_v) | set_v;
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= FLAGS_RESET[12:0];
      end else begin
         flags_r <= flags_nxt & ~(flag_mask_i & (13'h0001 << B_POR));
      end
   end

   // ---------------------------------------------------------------
   // Margin test
   // ---------------------------------------------------------------
   sffm_ms_t   ms_r, ms_nxt;
   logic [1:0] res_r, res_nxt;
   logic [1:0] sel_r, sel_nxt;
   always_comb begin
      ms_nxt  = ms_r;
      res_nxt = res_r;
      sel_nxt = sel_r;
      unique case (ms_r)
         MS_IDLE: begin
            if (mrg_start_i && mrg_sel_i != 2'h0) begin
               ms_nxt  = MS_RUN;
               sel_nxt = mrg_sel_i;
               res_nxt = 2'h0;
            end
         end
         MS_RUN: begin
            res_nxt[0] = sel_r[0] & ~mrg_cell_ok1_i;
            res_nxt[1] = sel_r[1] & ~mrg_cell_ok0_i;
            ms_nxt = MS_DONE;
         end
         MS_DONE: ms_nxt = MS_IDLE;
         default: ms_nxt = MS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ms_r  <= MS_IDLE;
         res_r <= 2'h0;
         sel_r <= 2'h0;
      end else begin
         ms_r  <= ms_nxt;
         res_r <= res_nxt;
         sel_r <= sel_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic [31:0] rd_nxt, rd_r;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (rd_en_i && rd_addr_i == FAULT_FLAGS_ADDR) rd_nxt = {19'h00000, flags_r};
      else if (rd_en_i && rd_addr_i == SQ_RADIUS_ADDR) rd_nxt = {15'h0000, radius_r};
   end
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) rd_r <= 32'h0000_0000;
      else rd_r <= rd_nxt;
   end
   assign rd_data_o     = rd_r;
   assign mrg_busy_o    = (ms_r != MS_IDLE);
   assign mrg_result_o  = res_r;
   // Margin results are kept out of the fault state on purpose
   assign fault_state_o = |flags_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   crit_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      $past(flags_r[B_OFE]) |-> flags_r[B_OFE])
      else $error("oscillator flag cleared");
   por_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !first_upd_r && $past(flags_r[B_POR]) |-> flags_r[B_POR])
      else $error("por cleared early");
   read_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      rd_flags && !set_v[B_ACF] |=> !flags_r[B_ACF])
      else $error("acf not cleared");
   set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      rd_flags && set_v[B_ACF] |=> flags_r[B_ACF])
      else $error("acf set lost");
   uncorr_sticky_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      $past(flags_r[B_NVM_UNCORR]) |-> flags_r[B_NVM_UNCORR])
      else $error("uncorrectable flag cleared");
   spe_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (rd_flags || report_done_i) && flags_r[B_SPE] |=> flags_r[B_SPE])
      else $error("parity flag cleared");
   read_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      rd_flags |=> rd_data_o[31:13] == 19'h00000)
      else $error("upper bits set");
   unmapped_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !(rd_en_i && (rd_addr_i == FAULT_FLAGS_ADDR || rd_addr_i == SQ_RADIUS_ADDR))
      |=> rd_data_o == 32'h0000_0000)
      else $error("read data not zero");
   mask_acf_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      flag_mask_i[B_ACF] && analog_bad_i && !flags_r[B_ACF] |=> !flags_r[B_ACF])
      else $error("masked acf set");
   mask_srr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      flag_mask_i[B_SRR] && !flags_r[B_SRR] |=> !flags_r[B_SRR])
      else $error("masked radius flag set");
   fault_out_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      flags_r[B_TSE] |-> fault_state_o)
      else $error("no fault state");
   // A flag may only rise at its own evaluation point
   tse_point_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !$past(flags_r[B_TSE]) && flags_r[B_TSE] |-> $past(tse_tick))
      else $error("temperature flag off tick");
   selftest_point_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      !$past(flags_r[B_SELFTEST]) && flags_r[B_SELFTEST] |-> $past(tick10))
      else $error("self-test flag off tick");
   mrg_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      ms_r == MS_IDLE && mrg_start_i && mrg_sel_i != 2'h0 |=> mrg_busy_o ##2 !mrg_busy_o)
      else $error("margin length");
   mrg_no_fault_a: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      ms_r == MS_RUN && set_v == 13'h0000 && !rd_flags && !report_done_i
      && !flag_mask_i[B_POR] |=> flags_r == $past(flags_r))
      else $error("margin changed flags");
endmodule

/* File: sim/sffm_ecu_model.sv */
// Output-protocol receiver model that strobes the end of each fault frame
`timescale 1ns/1ps
module sffm_ecu_model #(
   parameter int DELAY = 3
) (
   input  wire logic clk_i,
   input  wire logic send_i,
   output logic      report_done_o
);
   int cnt = 0;
   initial report_done_o = 1'b0;
   // Frame shortened: only the end-of-frame strobe matters to the flags
   always @(posedge clk_i) begin
      report_done_o <= (cnt == 1);
      if (send_i) cnt <= DELAY;
      else if (cnt != 0) cnt <= cnt - 1;
   end
endmodule

/* File: sim/tb_sffm_top.sv */
// Self-checking bench for the sensor fault flag monitor
`timescale 1ns/1ps
module tb_sffm_top;
   import sffm_pkg::*;
   logic        clk = 0;
   logic        rstn = 0;
   logic        rd_en = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] rdata;
   logic        upd = 0;
   logic [17:0] c = '0;
   logic [15:0] ax = 16'h0A00;
   logic [12:0] fm = 13'h0020;
   logic [3:0]  sm = 4'h0;
   logic [3:0]  ff = 4'h0;
   logic [8:0]  tmin = 9'h001;
   logic [8:0]  tmax = 9'h064;
   logic        mst = 0;
   logic [1:0]  msel = 2'h0;
   logic        send = 0;
   logic [1:0]  mok = 2'h0;
   logic [2:0]  aen = 3'h7;
   logic        rep, busy, fst;
   logic [1:0]  mres;
   logic [31:0] keep = '0;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          n;

   initial forever #20 clk = ~clk;

   sffm_top dut (
      .core_clk_i(clk), .resetn_i(rstn), .rd_en_i(rd_en), .rd_addr_i(addr),
      .rd_data_o(rdata), .report_done_i(rep), .angle_upd_i(upd),
      .analog_bad_i(c[0]), .clamp_hit_i(c[1]), .temp_hi_sat_i(c[2]), .temp_lo_i(c[3]),
      .sat_filt_i(c[4]), .sat_chan_i(c[5]), .pregain_out_i(c[6]), .gain_out_i(c[7]),
      .postgain_out_i(c[8]), .sat_lin_i(c[9]), .osc_dev_i(c[10]),
      .logic_selftest_fail_i(c[11]), .upd_late_i(c[12]), .uvd_i(c[13]), .ovd_i(c[14]),
      .ese_i(c[15]), .nvm_uncorrectable_i(c[16]), .spe_i(c[17]),
      .first_axis_value_i(ax), .second_axis_value_i(ax), .flag_mask_i(fm),
      .sat_filt_mask_i(sm[0]), .sat_chan_mask_i(sm[1]), .sat_cor_mask_i(sm[2]),
      .sat_lin_mask_i(sm[3]), .ang_thresh_en_i(aen[0]), .ang_gain_sat_en_i(aen[1]),
      .ang_offs_sat_en_i(aen[2]), .fault_filt_i(ff), .thresh_min_i(tmin),
      .thresh_max_i(tmax), .mrg_start_i(mst), .mrg_sel_i(msel),
      .mrg_cell_ok1_i(mok[0]), .mrg_cell_ok0_i(mok[1]), .mrg_busy_o(busy),
      .mrg_result_o(mres), .fault_state_o(fst)
   );

   sffm_ecu_model ecu (.clk_i(clk), .send_i(send), .report_done_o(rep));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Two temperature waits dominate the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         mismatches++;
         $display("[FAIL] %0t run too long", $time);
         final_report;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic pulse(input int k);
      repeat (k) begin
         @(posedge clk);
         upd <= 1'b1;
         @(posedge clk);
         upd <= 1'b0;
      end
      tick(2);
   endtask

   // Raise one condition, drop it, then expect set-then-cleared, or set-then-kept when crit
   task automatic fl(input int i, input int b, input int k, input bit crit);
      c[i] <= 1'b1;
      if (k == 0) tick(2);
      else pulse(k);
      c[i] <= 1'b0;
      tick(2);
      if (crit) keep[b] = 1'b1;
      rd(FAULT_FLAGS_ADDR, keep | (32'h1 << b));
      rd(FAULT_FLAGS_ADDR, keep);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   // ---------------------------------------------
   // Test sequence
   // ---------------------------------------------
   initial begin
      tick(8);
      rstn <= 1'b1;
      tick(3);
      rd(FAULT_FLAGS_ADDR, 32'h40);
      rd(FAULT_FLAGS_ADDR, 32'h40);
      // A report before the first update must not clear power-on
      send <= 1'b1;
      tick(1);
      send <= 1'b0;
      tick(6);
      rd(FAULT_FLAGS_ADDR, 32'h40);
      pulse(1);
      rd(FAULT_FLAGS_ADDR, 32'h40);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      rd(8'h10, 32'h0);
      done("power-on");
      fl(0, B_ACF, 0, 0);
      fl(13, B_UVD, 0, 0);
      fl(14, B_OVD, 0, 0);
      fl(15, B_ESE, 0, 0);
      fm <= 13'h0021;
      c[0] <= 1'b1;
      tick(3);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      fm <= 13'h0020;
      tick(2);
      rd(FAULT_FLAGS_ADDR, 32'h1);
      rd(FAULT_FLAGS_ADDR, 32'h1);
      c[0] <= 1'b0;
      tick(2);
      rd(FAULT_FLAGS_ADDR, 32'h1);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      c[13] <= 1'b1;
      tick(2);
      c[13] <= 1'b0;
      send <= 1'b1;
      tick(1);
      send <= 1'b0;
      tick(6);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      done("level flags");
      fl(1, B_AOC, 1, 0);
      // A clean update restarts the filter count
      pulse(1);
      ff <= 4'h2;
      c[1] <= 1'b1;
      pulse(2);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      pulse(1);
      rd(FAULT_FLAGS_ADDR, 32'h2);
      c[1] <= 1'b0;
      ff <= 4'h0;
      pulse(1);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      for (int i = 4; i < 10; i++) fl(i, B_SAT, 1, 0);
      sm <= 4'hF;
      c[9:4] <= 6'h3F;
      pulse(1);
      c[9:4] <= 6'h00;
      sm <= 4'h0;
      rd(FAULT_FLAGS_ADDR, 32'h0);
      aen <= 3'h0;
      c[8:6] <= 3'h7;
      pulse(1);
      c[8:6] <= 3'h0;
      aen <= 3'h7;
      rd(FAULT_FLAGS_ADDR, 32'h0);
      fl(11, B_SELFTEST, 10, 0);
      fl(12, B_SELFTEST, 10, 0);
      done("update flags");
      fm <= 13'h0000;
      ax <= 16'h7F80;
      pulse(2);
      rd(FAULT_FLAGS_ADDR, 32'h20);
      rd(SQ_RADIUS_ADDR, 2 * (32'h7F80 >> 7) * (32'h7F80 >> 7));
      ax <= 16'h0A00;
      pulse(2);
      rd(FAULT_FLAGS_ADDR, 32'h20);
      rd(FAULT_FLAGS_ADDR, 32'h0);
      done("radius");
      // Every pass/fail mix of the two cell checks against every selection
      for (int m = 0; m < 4; m++) begin
         mok <= 2'(m);
         for (int s = 1; s < 4; s++) begin
            @(posedge clk);
            mst  <= 1'b1;
            msel <= 2'(s);
            @(posedge clk);
            mst <= 1'b0;
            #1 chk({31'h0, busy}, 32'h1);
            tick(4);
            #1 chk({30'h0, mres}, 32'(s & ~m & 3));
            chk({31'h0, fst}, 32'h0);
            chk({31'h0, busy}, 32'h0);
         end
      end
      done("margin");
      for (int i = 2; i < 4; i++) begin
         c[i] <= 1'b1;
         n = 0;
         while (fst !== 1'b1 && n < 41000) begin
            @(posedge clk);
            n++;
         end
         chk({31'h0, n <= 40500}, 32'h1);
         c[i] <= 1'b0;
         tick(2);
         rd(FAULT_FLAGS_ADDR, 32'h4);
         rd(FAULT_FLAGS_ADDR, 32'h0);
      end
      done("temperature");
      fl(16, B_NVM_UNCORR, 0, 1);
      fl(17, B_SPE, 0, 1);
      fl(10, B_OFE, 10, 1);
      rstn <= 1'b0;
      tick(3);
      rstn <= 1'b1;
      tick(3);
      rd(FAULT_FLAGS_ADDR, 32'h40);
      done("critical");
      final_report;
   end
endmodule
